//--- core/smb_pkg.sv
// shared constants and types of the bus slave register port
package smb_pkg;

    localparam logic [6:0] ADDR_FLOAT = 7'h5C;
    localparam logic [6:0] ADDR_LOW   = 7'h58;

    localparam logic [1:0] STRAP_LOW   = 2'h0;
    localparam logic [1:0] STRAP_FLOAT = 2'h1;
    localparam logic [1:0] STRAP_HIGH  = 2'h2;

    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    localparam logic [3:0] BITS_BYTE = 4'h8;

    localparam logic [1:0] PH_ADDR = 2'h0;
    localparam logic [1:0] PH_PTR  = 2'h1;
    localparam logic [1:0] PH_DATA = 2'h2;
    localparam logic [1:0] PH_OVER = 2'h3;

    localparam int unsigned CLK_NS = 100;
    localparam int unsigned TMO_MS = 25;
    localparam int unsigned TMO_NS = TMO_MS * 1000000;
    localparam int unsigned TMO_W  = 18;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RX   = 2'b01,
        ST_ACK  = 2'b10,
        ST_TX   = 2'b11
    } smb_st_e;

    typedef struct packed {
        logic       stb;
        logic [7:0] addr;
        logic [7:0] data;
    } smb_wr_s;

    typedef struct packed {
        smb_st_e          st;
        logic [3:0]       bitcnt;
        logic [1:0]       phase;
        logic             rw;
        logic [7:0]       shreg;
        logic [7:0]       ptr;
        logic             wr_stb;
        logic [7:0]       wr_data;
        logic             rel;
        logic             scl_q;
        logic             sda_q;
        logic [TMO_W-1:0] tmo;
        logic [1:0]       strap_cnt;
        logic             strap_done;
        logic             addr_ok;
        logic [6:0]       own_addr;
    } smb_state_s;

endpackage

//--- core/smb_slave_port.sv
// bus slave port: start/stop, address match, pointer, byte transfers
// What this block does
// [RULE1] answer at 0x5C when floating, 0x58 when low
// [RULE2] sample address strap once after power-up
// [RULE3] ignore later strap changes until next power-up
// [RULE4] bus commands never alter the fixed address
// [RULE5] start condition begins address byte reception
// [RULE6] shift in seven address bits then direction
// [RULE7] acknowledge own address before ninth clock
// [RULE8] direction zero writes, one reads
// [RULE9] each byte is eight bits plus acknowledge
// [RULE10] data changes with clock low; rise is stop
// [RULE11] master ends write with stop
// [RULE12] master ends read with nack then stop
// [RULE13] direction fixed until a new start
// [RULE14] writes of one or two bytes; one-byte reads
// [RULE15] first written byte loads the address pointer
// [RULE16] second written byte goes to pointed register
// [RULE17] read returns register under current pointer
// [RULE18] send byte sets pointer, writes nothing
// [RULE19] repeated start accepted in place of stop
// [RULE20] pointer write, repeated start, one-byte read
// [RULE21] optional 25 ms idle timeout releases bus
// [RULE22] foreign address: stay released until next start
// [RULE23] start or stop mid-byte restarts reception
`timescale 1ns/1ps
`default_nettype none
module smb_slave_port #(
    parameter int unsigned TMO_CYC = smb_pkg::TMO_NS / smb_pkg::CLK_NS
) (
    input  wire logic           mclk,
    input  wire logic           sys_rst,
    input  wire logic           scl_i,
    input  wire logic           sda_i,
    output logic                sda_o,
    output logic                sda_oe_n,
    input  wire logic [1:0]     addr_strap,
    input  wire logic           tmo_en,
    output logic      [7:0]     reg_ptr,
    input  wire logic [7:0]     rd_data,
    output smb_pkg::smb_wr_s    wr,
    output logic                addr_valid
);
    import smb_pkg::*;

    if (TMO_CYC == 0 || TMO_CYC >= (1 << TMO_W))
    begin : g_chk
        $error("TMO_CYC out of range for timeout counter");
    end

    localparam logic [TMO_W-1:0] TMO_LIM = TMO_W'(TMO_CYC);

    smb_state_s r_ff;
    smb_state_s nxt_r;
    logic [3:0] pin_s;
    logic       scl_s;
    logic       sda_s;
    logic [1:0] strap_s;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic       byte_fall;
    logic       addr_hit;

    smb_sync #(
        .W (4)
    ) u_sync (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .din     ({addr_strap, sda_i, scl_i}),
        .dout    (pin_s)
    );

    // sync flops reset low, so an idle bus looks like a fall and rise
    // right after reset; the idle state ignores both
    assign scl_s   = pin_s[0];
    assign sda_s   = pin_s[1];
    assign strap_s = pin_s[3:2];

    assign scl_rise  = scl_s && !r_ff.scl_q;
    assign scl_fall  = !scl_s && r_ff.scl_q;
    // sda moves while scl stays high
    assign start_det = scl_s && r_ff.scl_q && r_ff.sda_q && !sda_s; // RULE5
    assign stop_det  = scl_s && r_ff.scl_q && !r_ff.sda_q && sda_s; // RULE10
    // an expiring idle timer wins over a late byte end
    assign byte_fall = (r_ff.st == ST_RX) && (r_ff.bitcnt == BITS_BYTE)
                       && scl_fall && !start_det && !stop_det
                       && !(tmo_en && r_ff.tmo == TMO_LIM);
    assign addr_hit  = r_ff.addr_ok && (r_ff.shreg[7:1] == r_ff.own_addr);

    always_comb
    begin
        nxt_r        = r_ff;
        nxt_r.scl_q  = scl_s;
        nxt_r.sda_q  = sda_s;
        nxt_r.wr_stb = 1'b0;

        // strap caught once the synchroniser has settled, never again
        if (!r_ff.strap_done) // RULE3 RULE4
        begin
            if (r_ff.strap_cnt == STRAP_SETTLE)
            begin
                nxt_r.strap_done = 1'b1; // RULE2
                nxt_r.addr_ok    = (strap_s != STRAP_HIGH); // RULE1
                nxt_r.own_addr   = (strap_s == STRAP_LOW) ? ADDR_LOW
                                                          : ADDR_FLOAT; // RULE1
            end
            else
            begin
                nxt_r.strap_cnt = r_ff.strap_cnt + 2'h1;
            end
        end

        // idle timer restarts on any line activity
        if (r_ff.st == ST_IDLE || scl_s != r_ff.scl_q
            || sda_s != r_ff.sda_q)
        begin
            nxt_r.tmo = '0;
        end
        else if (r_ff.tmo != TMO_LIM)
        begin
            nxt_r.tmo = r_ff.tmo + 1'b1;
        end

        if (start_det)
        begin
            // also serves as repeated start; pointer survives
            nxt_r.st     = ST_RX; // RULE19 RULE20 RULE23
            nxt_r.bitcnt = '0;
            nxt_r.phase  = PH_ADDR;
            nxt_r.rel    = 1'b1;
        end
        else if (stop_det)
        begin
            nxt_r.st  = ST_IDLE; // RULE10 RULE11 RULE12 RULE23
            nxt_r.rel = 1'b1;
        end
        else if (tmo_en && r_ff.tmo == TMO_LIM)
        begin
            nxt_r.st  = ST_IDLE; // RULE21
            nxt_r.rel = 1'b1;
        end
        else
        begin
            unique case (r_ff.st)
                ST_IDLE:
                begin
                    nxt_r.rel = 1'b1; // RULE22
                end
                ST_RX:
                begin
                    if (scl_rise && r_ff.bitcnt != BITS_BYTE)
                    begin
                        // msb first, sampled while scl high
                        nxt_r.shreg  = {r_ff.shreg[6:0], sda_s}; // RULE6
                        nxt_r.bitcnt = r_ff.bitcnt + 4'h1; // RULE9
                    end
                    else if (byte_fall)
                    begin
                        unique case (r_ff.phase)
                            PH_ADDR:
                            begin
                                if (addr_hit)
                                begin
                                    nxt_r.rw  = r_ff.shreg[0]; // RULE8 RULE13
                                    nxt_r.st  = ST_ACK;
                                    nxt_r.rel = 1'b0; // RULE7
                                    // read byte picked up at ack time
                                    nxt_r.shreg = rd_data; // RULE17
                                end
                                else
                                begin
                                    nxt_r.st = ST_IDLE; // RULE22
                                end
                            end
                            PH_PTR:
                            begin
                                nxt_r.ptr = r_ff.shreg; // RULE15 RULE18
                                nxt_r.st  = ST_ACK;
                                nxt_r.rel = 1'b0;
                            end
                            PH_DATA:
                            begin
                                nxt_r.wr_stb  = 1'b1; // RULE16
                                nxt_r.wr_data = r_ff.shreg;
                                nxt_r.st      = ST_ACK;
                                nxt_r.rel     = 1'b0;
                            end
                            PH_OVER:
                            begin
                                // third write byte left unacknowledged
                                nxt_r.st = ST_IDLE; // RULE14
                            end
                        endcase
                    end
                end
                ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        nxt_r.bitcnt = '0;
                        if (r_ff.rw)
                        begin
                            nxt_r.st  = ST_TX;
                            nxt_r.rel = r_ff.shreg[7];
                        end
                        else
                        begin
                            nxt_r.st    = ST_RX;
                            nxt_r.rel   = 1'b1;
                            nxt_r.phase = r_ff.phase + 2'h1;
                        end
                    end
                end
                ST_TX:
                begin
                    if (scl_fall)
                    begin
                        nxt_r.bitcnt = r_ff.bitcnt + 4'h1;
                        nxt_r.shreg  = {r_ff.shreg[6:0], 1'b1};
                        if (r_ff.bitcnt == BITS_BYTE - 4'h1)
                        begin
                            // one byte only; master's ack slot ignored
                            nxt_r.st  = ST_IDLE; // RULE14
                            nxt_r.rel = 1'b1;
                        end
                        else
                        begin
                            nxt_r.rel = r_ff.shreg[6]; // RULE10
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            r_ff     <= '0;
            r_ff.st  <= ST_IDLE;
            r_ff.rel <= 1'b1;
            r_ff.scl_q <= 1'b1;
            r_ff.sda_q <= 1'b1;
        end
        else
        begin
            r_ff <= nxt_r;
        end
    end

    // open drain: only ever pulls low
    assign sda_o      = 1'b0;
    assign sda_oe_n   = r_ff.rel;
    assign reg_ptr    = r_ff.ptr;
    assign wr         = '{stb:  r_ff.wr_stb,
                          addr: r_ff.ptr,
                          data: r_ff.wr_data};
    assign addr_valid = r_ff.strap_done && r_ff.addr_ok;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    sequence s_addr_byte_done;
        byte_fall && r_ff.phase == PH_ADDR;
    endsequence

    sequence s_ack_then_release;
        (r_ff.st == ST_ACK && !r_ff.rel) ##1 (r_ff.st == ST_ACK);
    endsequence

    a_strap_value: assert property ( // RULE1
        r_ff.strap_done && r_ff.addr_ok |->
            (r_ff.own_addr == ADDR_FLOAT || r_ff.own_addr == ADDR_LOW))
        else $error("latched address not a strap choice");

    a_strap_latched: assert property ( // RULE3
        r_ff.strap_done |=> r_ff.strap_done && $stable(r_ff.own_addr)
            && $stable(r_ff.addr_ok))
        else $error("latched address changed");

    a_addr_fixed: assert property ( // RULE4
        $past(r_ff.strap_done) |-> r_ff.own_addr == $past(r_ff.own_addr))
        else $error("own address altered by bus");

    a_ack_match: assert property ( // RULE7
        s_addr_byte_done ##0 addr_hit |=> s_ack_then_release)
        else $error("own address not acknowledged");

    a_no_ack_miss: assert property ( // RULE22
        s_addr_byte_done ##0 !addr_hit |=> r_ff.st == ST_IDLE && r_ff.rel
            ##1 r_ff.rel)
        else $error("foreign address disturbed sda");

    a_start_restart: assert property ( // RULE23
        start_det |=> r_ff.st == ST_RX && r_ff.bitcnt == 4'h0
            && r_ff.phase == PH_ADDR && r_ff.rel)
        else $error("start did not restart reception");

    a_stop_idle: assert property ( // RULE10
        stop_det |=> r_ff.st == ST_IDLE && sda_oe_n)
        else $error("stop did not release bus");

    a_ptr_load: assert property ( // RULE15
        byte_fall && r_ff.phase == PH_PTR |=> reg_ptr == $past(r_ff.shreg)
            && !wr.stb)
        else $error("pointer not loaded from first byte");

    a_wr_pulse: assert property ( // RULE16
        wr.stb |-> $past(r_ff.phase) == PH_DATA && wr.addr == reg_ptr
            && wr.data == $past(r_ff.shreg)
            ##1 !wr.stb)
        else $error("register write malformed");

    a_read_load: assert property ( // RULE17
        s_addr_byte_done ##0 (addr_hit && r_ff.shreg[0]) |=>
            r_ff.shreg == $past(rd_data) && r_ff.rw)
        else $error("read byte not taken from pointed register");

    // rw only moves when an address byte is taken
    a_dir_fixed: assert property ( // RULE13
        !(byte_fall && r_ff.phase == PH_ADDR) |=> $stable(r_ff.rw))
        else $error("direction changed mid transfer");

    a_timeout: assert property ( // RULE21
        tmo_en && r_ff.tmo == TMO_LIM && !start_det && !stop_det
            |=> r_ff.st == ST_IDLE && sda_oe_n)
        else $error("timeout did not release bus");

    a_tmo_off: assert property ( // RULE21
        !tmo_en && r_ff.st == ST_TX && !scl_fall && !start_det && !stop_det
            |=> r_ff.st == ST_TX)
        else $error("transfer dropped with timeout off");

    a_tx_drive: assert property ( // RULE14
        r_ff.st == ST_TX && scl_fall && r_ff.bitcnt == 4'h7
            |=> r_ff.st == ST_IDLE [*2])
        else $error("more than one read byte supplied");
endmodule
`default_nettype wire

//--- core/smb_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module smb_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } smb_sync_s;

    smb_sync_s r_ff;
    smb_sync_s nxt_r;

    if (W == 0)
    begin : g_chk
        $error("smb_sync width must be nonzero");
    end

    always_comb
    begin
        nxt_r.meta = din;
        nxt_r.sync = r_ff.meta;
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            r_ff <= '0;
        end
        else
        begin
            r_ff <= nxt_r;
        end
    end

    assign dout = r_ff.sync;
endmodule
`default_nettype wire

//--- tb/smb_host_model.sv
// host model: drives clock and data of the two-wire link
`timescale 1ns/1ps
`default_nettype none
module smb_host_model (
    output logic      scl,
    output logic      sda_drv,
    input  wire logic sda_bus
);
    // clock idles high between frames, data released
    initial
    begin
        scl     = 1'b1;
        sda_drv = 1'b1;
    end

    // one clock pulse: data set in low phase, sampled mid high
    task automatic bit_x(input logic b, output logic s);
        #100 sda_drv = b;
        #400 scl = 1'b1;
        #150 s = sda_bus;
        #150 scl = 1'b0;
    endtask

    task automatic start_c();
        if (!scl)
        begin
            #100 sda_drv = 1'b1;
            #400 scl = 1'b1;
        end
        #150 sda_drv = 1'b0;
        #150 scl = 1'b0;
    endtask

    task automatic stop_c();
        #100 sda_drv = 1'b0;
        #400 scl = 1'b1;
        #150 sda_drv = 1'b1;
        #150;
    endtask

    // eight bits first to last, then the acknowledge slot
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], s);
        bit_x(1'b1, s);
        ack = ~s;
    endtask

    // read keeps one direction until a new start
    task automatic recv_byte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_x(1'b1, d[i]);
        bit_x(nack, s);
    endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench of the bus slave register port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import smb_pkg::*;

    // kind: 0 write, 1 send, 2 receive, 3 pointer then read
    typedef struct packed {
        logic [1:0] kind;
        logic [6:0] addr;
        logic [7:0] ptr;
        logic [7:0] data;
        logic       ack;
        logic [7:0] exp;
    } smb_row_s;

    logic       mclk;
    logic       sys_rst;
    logic       scl;
    logic       sda_drv;
    logic       sda_o;
    logic       sda_oe_n;
    logic [1:0] addr_strap;
    logic       tmo_en;
    logic [7:0] reg_ptr;
    logic [7:0] rd_data;
    smb_wr_s    wr;
    logic       addr_valid;
    wire        sda_bus = sda_drv & (sda_oe_n | sda_o);
    logic [7:0] regs [256];
    int         wr_cnt = 0;
    int         err_count = 0;
    int         cmp_count = 0;
    int         cyc = 0;

    smb_row_s rows [9] = '{
        '{2'h0, ADDR_FLOAT, 8'h10, 8'hA5, 1'b1, 8'h00},
        '{2'h1, ADDR_FLOAT, 8'h20, 8'h00, 1'b1, 8'h00},
        '{2'h2, ADDR_FLOAT, 8'h00, 8'h00, 1'b1, 8'hDF},
        '{2'h3, ADDR_FLOAT, 8'h10, 8'h00, 1'b1, 8'hA5},
        '{2'h0, ADDR_LOW,   8'h30, 8'h11, 1'b0, 8'h00},
        '{2'h2, ADDR_LOW,   8'h00, 8'h00, 1'b0, 8'hFF},
        '{2'h2, ADDR_FLOAT, 8'h00, 8'h00, 1'b1, 8'hA5},
        '{2'h0, ADDR_FLOAT, 8'hFF, 8'h3C, 1'b1, 8'h00},
        '{2'h3, ADDR_FLOAT, 8'hFF, 8'h00, 1'b1, 8'h3C}
    };

    smb_slave_port #(
        .TMO_CYC (200)
    ) DUT (
        .mclk       (mclk),
        .sys_rst    (sys_rst),
        .scl_i      (scl),
        .sda_i      (sda_bus),
        .sda_o      (sda_o),
        .sda_oe_n   (sda_oe_n),
        .addr_strap (addr_strap),
        .tmo_en     (tmo_en),
        .reg_ptr    (reg_ptr),
        .rd_data    (rd_data),
        .wr         (wr),
        .addr_valid (addr_valid)
    );

    smb_host_model host (
        .scl     (scl),
        .sda_drv (sda_drv),
        .sda_bus (sda_bus)
    );

    // register file behind the pointer
    assign rd_data = regs[reg_ptr];

    always @(posedge mclk)
    begin
        if (wr.stb === 1'b1)
        begin
            regs[wr.addr] <= wr.data;
            wr_cnt        <= wr_cnt + 1;
        end
    end

    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            err_count++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1)
        begin
            $display("MISMATCH t=%0t %s", $time, msg);
            err_count++;
        end
    endtask

    // link moves off the system clock edges
    task automatic sync_bus();
        @(posedge mclk);
        #13;
    endtask

    task automatic do_reset(input logic [1:0] strap);
        @(posedge mclk);
        sys_rst    <= 1'b1;
        addr_strap <= strap;
        repeat (10) @(posedge mclk);
        chk(sda_oe_n === 1'b1 && reg_ptr === 8'h00 && wr.stb === 1'b0
            && addr_valid === 1'b0, "reset values");
        sys_rst <= 1'b0;
        repeat (12) @(posedge mclk);
        chk(addr_valid === (strap != STRAP_HIGH), "strap latch");
    endtask

    task automatic run_row(input smb_row_s r);
        logic       a;
        logic       b;
        logic [7:0] d;
        int         n;
        n = wr_cnt;
        d = 8'h00;
        sync_bus();
        host.start_c();
        host.send_byte({r.addr, r.kind == 2'h2}, a);
        chk(a === r.ack, "address acknowledge");
        if (r.kind != 2'h2)
        begin
            host.send_byte(r.ptr, b);
            if (r.kind == 2'h0)
                host.send_byte(r.data, b);
        end
        if (r.kind == 2'h3)
        begin
            host.start_c();
            host.send_byte({r.addr, 1'b1}, b);
        end
        if (r.kind[1])
            host.recv_byte(1'b1, d);
        host.stop_c();
        repeat (8) @(posedge mclk);
        chk(wr_cnt == n + int'(r.kind == 2'h0 && r.ack), "strobes");
        if (r.kind[1])
            chk(d === r.exp, "read data");
        if (!r.kind[1] && r.ack)
            chk(reg_ptr === r.ptr, "pointer load");
        if (r.kind == 2'h0 && r.ack)
            chk(regs[r.ptr] === r.data, "register write");
    endtask

    initial
    begin
        logic a;
        int   n;
        sys_rst    = 1'b1;
        addr_strap = STRAP_FLOAT;
        tmo_en     = 1'b0;
        for (int i = 0; i < 256; i++)
            regs[i] = ~8'(i);
        do_reset(STRAP_FLOAT);
        for (int i = 0; i < 9; i++)
            run_row(rows[i]);
        // strap moved after power-up: address kept
        @(posedge mclk);
        addr_strap <= STRAP_LOW;
        run_row('{2'h2, ADDR_FLOAT, 8'h00, 8'h00, 1'b1, 8'h3C});
        run_row('{2'h2, ADDR_LOW, 8'h00, 8'h00, 1'b0, 8'hFF});
        // start in mid byte, then a refused third byte
        n = wr_cnt;
        sync_bus();
        host.start_c();
        repeat (4) host.bit_x(1'b1, a);
        host.start_c();
        host.send_byte({ADDR_FLOAT, 1'b0}, a);
        chk(a === 1'b1, "restart mid byte");
        host.send_byte(8'h40, a);
        host.send_byte(8'h55, a);
        host.send_byte(8'h66, a);
        chk(a === 1'b0, "third byte refused");
        host.stop_c();
        repeat (8) @(posedge mclk);
        chk(regs[8'h40] === 8'h55 && wr_cnt == n + 1, "two-byte write");
        // stalled read: held while timeout off, released once on
        sync_bus();
        host.start_c();
        host.send_byte({ADDR_FLOAT, 1'b0}, a);
        host.send_byte(8'h80, a);
        host.start_c();
        host.send_byte({ADDR_FLOAT, 1'b1}, a);
        repeat (6) @(posedge mclk);
        chk(sda_oe_n === 1'b0, "first read bit driven");
        repeat (250) @(posedge mclk);
        chk(sda_oe_n === 1'b0, "held with timeout off");
        tmo_en <= 1'b1;
        repeat (250) @(posedge mclk);
        chk(sda_oe_n === 1'b1, "idle timeout release");
        sync_bus();
        host.stop_c();
        @(posedge mclk);
        tmo_en <= 1'b0;
        // low strap, then high strap
        do_reset(STRAP_LOW);
        run_row('{2'h1, ADDR_LOW, 8'h22, 8'h00, 1'b1, 8'h00});
        run_row('{2'h2, ADDR_FLOAT, 8'h00, 8'h00, 1'b0, 8'hFF});
        do_reset(STRAP_HIGH);
        run_row('{2'h2, ADDR_LOW, 8'h00, 8'h00, 1'b0, 8'hFF});
        run_row('{2'h2, ADDR_FLOAT, 8'h00, 8'h00, 1'b0, 8'hFF});
        final_report();
    end
endmodule
`default_nettype wire
